// *** include/mem_decode_pkg.sv ***
// Constants for the on-chip memory decoder
package mem_decode_pkg;
  localparam int          RAM_BYTES      = 256;
  localparam logic [7:0]  UPPER_BASE     = 8'h80;
  localparam logic [7:0]  LOWER_TOP      = 8'h7F;
  localparam logic [7:0]  BANK_TOP       = 8'h1F;
  localparam logic [7:0]  BIT_BASE       = 8'h20;
  localparam logic [7:0]  BIT_TOP        = 8'h2F;
  localparam int          BANK_BYTES     = 8;
  localparam logic [7:0]  RAM_RESET      = 8'h00;
  localparam int          FLASH_8K       = 8192;
  localparam int          FLASH_4K       = 4096;
  localparam int          FLASH_2K       = 2048;
  localparam logic [12:0] FLASH_START    = 13'h0000;
  localparam int          SECTOR_BYTES   = 512;
  localparam logic [12:0] FLASH_RES_BASE = 13'h1E00;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_ERASE = 2'b01
  } flash_state_t;
endpackage

// *** rtl/mem_decode.sv ***
// On-chip data RAM, register-space decode and program flash
`timescale 1ns/1ps
// How it works
// R1 - 256 RAM bytes; upper half shares addresses with register space.
// R2 - Indirect access above 0x7F reaches upper RAM half.
// R3 - Direct access 0x80..0xFF goes to the register space port.
// R4 - Lower half reached alike by direct and indirect access.
// R5 - Bytes 0x00..0x1F form four working register banks.
// R6 - Bytes 0x20..0x2F take byte and single-bit accesses.
// R7 - Flash of 8k, 4k or 2k bytes from address 0x0000.
// R8 - Flash erased in-system by 512-byte sectors and rewritten byte by byte.
// R9 - Bit n hits bit n%8 of byte 0x20+n/8; other bits kept.
// R10 - Register r maps to byte 8*bank+r.
module mem_decode
  import mem_decode_pkg::*;
#(
  parameter int FLASH_BYTES = FLASH_8K
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Data access from the core
  input  wire logic        dat_req,
  input  wire logic        dat_we,
  input  wire logic        dat_indirect,
  input  wire logic [7:0]  dat_addr,
  input  wire logic [7:0]  dat_wdata,
  output logic      [7:0]  dat_rdata,
  // Working register access
  input  wire logic        reg_req,
  input  wire logic        reg_we,
  input  wire logic [1:0]  reg_bank,
  input  wire logic [2:0]  reg_idx,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Single-bit access
  input  wire logic        bit_req,
  input  wire logic        bit_we,
  input  wire logic [6:0]  bit_addr,
  input  wire logic        bit_wdata,
  output logic             bit_rdata,
  // Register space port
  output logic             sfr_sel,
  output logic             sfr_we,
  output logic      [6:0]  sfr_addr,
  output logic      [7:0]  sfr_wdata,
  input  wire logic [7:0]  sfr_rdata,
  // Program fetch and flash programming
  input  wire logic [12:0] code_addr,
  output logic      [7:0]  code_data,
  input  wire logic        fl_write,
  input  wire logic        fl_erase,
  input  wire logic [12:0] fl_addr,
  input  wire logic [7:0]  fl_wdata,
  output logic             fl_busy
);
  localparam int FL_AW = $clog2(FLASH_BYTES);

  logic [7:0] ram_r   [RAM_BYTES];
  logic [7:0] ram_nxt [RAM_BYTES];
  logic [7:0] flash_r [FLASH_BYTES];
  logic [7:0] flash_nxt [FLASH_BYTES];

  // Registered read data
  logic [7:0]       dat_rdata_r;
  logic [7:0]       dat_rdata_nxt;
  logic [7:0]       reg_rdata_r;
  logic [7:0]       reg_rdata_nxt;
  logic             bit_rdata_r;
  logic             bit_rdata_nxt;
  logic [7:0]       code_data_r;
  logic [7:0]       code_data_nxt;
  logic             sfr_rd_r;
  logic             sfr_rd_nxt;

  // Flash sector erase state
  flash_state_t     fl_state_r;
  flash_state_t     fl_state_nxt;
  logic [8:0]       fl_cnt_r;
  logic [8:0]       fl_cnt_nxt;
  logic [FL_AW-1:0] fl_base_r;
  logic [FL_AW-1:0] fl_base_nxt;

  // Write strobes into RAM
  logic       dat_wr_hit;
  logic       reg_wr_hit;
  logic       bit_wr_hit;

  logic       to_sfr;
  logic [7:0] reg_byte;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic       fl_in_range;

  // Direct upper-half access goes to register space
  assign to_sfr = dat_req && !dat_indirect && (dat_addr > LOWER_TOP); // R3
  assign sfr_sel   = to_sfr;
  assign sfr_we    = to_sfr && dat_we;
  assign sfr_addr  = dat_addr[6:0];
  assign sfr_wdata = dat_wdata;

  assign reg_byte = {3'b000, reg_bank, reg_idx}; // R5 R10
  assign bit_byte = BIT_BASE + {4'h0, bit_addr[6:3]}; // R6 R9
  assign bit_pos  = bit_addr[2:0]; // R9
  assign fl_in_range = ({19'h0, fl_addr} < FLASH_BYTES); // R7

  // Lower half by either mode, upper half only indirect
  assign dat_wr_hit = dat_req && dat_we && !to_sfr; // R1 R2 R4
  assign reg_wr_hit = reg_req && reg_we; // R10
  assign bit_wr_hit = bit_req && bit_we; // R9

  // RAM bytes; bit write wins over register over data write
  for (genvar g = 0; g < RAM_BYTES; g++) begin : g_ram
    always_comb begin
      ram_nxt[g] = ram_r[g];
      if (dat_wr_hit && (dat_addr == 8'(g))) begin
        ram_nxt[g] = dat_wdata; // R1 R2 R4
      end
      if (reg_wr_hit && (reg_byte == 8'(g))) begin
        ram_nxt[g] = reg_wdata; // R5 R10
      end
      if (bit_wr_hit && (bit_byte == 8'(g))) begin
        ram_nxt[g][bit_pos] = bit_wdata; // R6 R9
      end
    end

    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        ram_r[g] <= RAM_RESET;
      end else begin
        ram_r[g] <= ram_nxt[g];
      end
    end
  end

  // Read data next state
  always_comb begin
    dat_rdata_nxt = dat_rdata_r;
    sfr_rd_nxt    = 1'b0;
    if (dat_req && !dat_we) begin
      dat_rdata_nxt = ram_r[dat_addr]; // R2 R4
      sfr_rd_nxt    = to_sfr; // R3
    end
    reg_rdata_nxt = reg_req ? ram_r[reg_byte] : reg_rdata_r; // R10
    bit_rdata_nxt = bit_req ? ram_r[bit_byte][bit_pos] : bit_rdata_r; // R9
    code_data_nxt = flash_r[code_addr[FL_AW-1:0]]; // R7
  end

  // Flash programming next state
  always_comb begin
    fl_state_nxt = fl_state_r;
    fl_cnt_nxt   = fl_cnt_r;
    fl_base_nxt  = fl_base_r;
    for (int i = 0; i < FLASH_BYTES; i++) begin
      flash_nxt[i] = flash_r[i];
    end
    case (fl_state_r)
      FL_IDLE: begin
        if (fl_erase && fl_in_range) begin
          fl_base_nxt  = {fl_addr[FL_AW-1:9], 9'h000}; // R8
          fl_cnt_nxt   = 9'h000;
          fl_state_nxt = FL_ERASE;
        end else if (fl_write && fl_in_range) begin
          // Programming only clears bits, like real flash
          flash_nxt[fl_addr[FL_AW-1:0]] =
            flash_r[fl_addr[FL_AW-1:0]] & fl_wdata; // R8
        end
      end
      FL_ERASE: begin
        flash_nxt[fl_base_r | FL_AW'(fl_cnt_r)] = ERASED_BYTE; // R8
        fl_cnt_nxt = fl_cnt_r + 9'h001;
        if (fl_cnt_r == 9'(SECTOR_BYTES - 1)) begin
          fl_state_nxt = FL_IDLE;
        end
      end
      default: fl_state_nxt = FL_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dat_rdata_r <= 8'h00;
      reg_rdata_r <= 8'h00;
      bit_rdata_r <= 1'b0;
      code_data_r <= 8'h00;
      sfr_rd_r    <= 1'b0;
      fl_state_r  <= FL_IDLE;
      fl_cnt_r    <= 9'h000;
      fl_base_r   <= '0;
    end else begin
      dat_rdata_r <= dat_rdata_nxt;
      reg_rdata_r <= reg_rdata_nxt;
      bit_rdata_r <= bit_rdata_nxt;
      code_data_r <= code_data_nxt;
      sfr_rd_r    <= sfr_rd_nxt;
      fl_state_r  <= fl_state_nxt;
      fl_cnt_r    <= fl_cnt_nxt;
      fl_base_r   <= fl_base_nxt;
    end
  end

  // Flash keeps contents over reset
  always_ff @(posedge clk) begin
    flash_r <= flash_nxt;
  end

  assign dat_rdata = sfr_rd_r ? sfr_rdata : dat_rdata_r; // R3
  assign reg_rdata = reg_rdata_r;
  assign bit_rdata = bit_rdata_r;
  assign code_data = code_data_r;
  assign fl_busy   = (fl_state_r == FL_ERASE);

endmodule // mem_decode

// *** sim/mem_decode_monitor.sv ***
// Checker for the memory decoder ports
`timescale 1ns/1ps
module mem_decode_monitor (
  // Watched ports
  input wire logic clk, rst_b, dat_req, dat_we, dat_indirect, bit_req,
  input wire logic bit_rdata, fl_erase, fl_busy, sfr_sel, sfr_we,
  input wire logic [6:0] sfr_addr,
  input wire logic [7:0] dat_addr, dat_rdata, sfr_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_sfr_sel: assert property (
    sfr_sel == (dat_req && !dat_indirect && dat_addr[7])) else $error("sel");
  chk_sfr_we: assert property (sfr_we == (sfr_sel && dat_we))
    else $error("bad we");
  chk_sfr_addr: assert property (sfr_sel |-> sfr_addr == dat_addr[6:0])
    else $error("bad addr");
  chk_sfr_read: assert property (
    sfr_sel && !sfr_we |=> dat_rdata == sfr_rdata) else $error("bad read");
  chk_erase_start: assert property ($rose(fl_busy) |-> $past(fl_erase))
    else $error("busy uncaused");
  chk_erase_hold: assert property ($rose(fl_busy) |-> fl_busy[*8])
    else $error("busy dropped");
  chk_erase_span: assert property (
    $rose(fl_busy) |-> ##[511:511] fl_busy ##1 !fl_busy) else $error("span");
  chk_bit_hold: assert property (!bit_req |=> $stable(bit_rdata))
    else $error("bit moved");
endmodule // mem_decode_monitor
bind mem_decode mem_decode_monitor mon (.*);

// *** sim/sfr_model.sv ***
// Register space model behind the register port
`timescale 1ns/1ps
module sfr_model (
  // Register port
  input wire logic clk, sfr_sel, sfr_we,
  input wire logic [6:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata = 8'h00
);
  logic [7:0] space_r [128];
  always @(posedge clk) begin
    if (sfr_sel && sfr_we) space_r[sfr_addr] <= sfr_wdata;
    sfr_rdata <= sfr_sel && !sfr_we ? space_r[sfr_addr] : ~sfr_rdata;
  end
endmodule // sfr_model

// *** sim/mem_decode_test.sv ***
// Self-checking bench for the memory decoder
`timescale 1ns/1ps
module mem_decode_test;
  import mem_decode_pkg::*;
  logic clk = 0, rst_b = 0, dat_req = 0, dat_we = 0, dat_indirect = 0;
  logic reg_req = 0, reg_we = 0, bit_req = 0, bit_we = 0, bit_wdata = 0;
  logic fl_write = 0, fl_erase = 0, bit_rdata, sfr_sel, sfr_we, fl_busy;
  logic [7:0] dat_addr = '0, dat_wdata = '0, reg_wdata = '0, fl_wdata = '0;
  logic [7:0] dat_rdata, reg_rdata, sfr_wdata, sfr_rdata, code_data;
  logic [12:0] code_addr = '0, fl_addr = '0;
  logic [6:0] bit_addr = '0, sfr_addr;
  logic [2:0] reg_idx = '0;
  logic [1:0] reg_bank = '0;
  int error_cnt = 0, n_checks = 0;
  mem_decode #(.FLASH_BYTES(FLASH_2K)) dut (.*);
  sfr_model sfr (.*);
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step;
    @(negedge clk);
  endtask
  task automatic rest;
    {dat_req, reg_req, bit_req, fl_write, fl_erase} = 5'h00;
    @(negedge clk);
  endtask
  task automatic dacc(input logic we, ind, input logic [7:0] a, d);
    {dat_req, dat_we, dat_indirect} = {1'b1, we, ind};
    {dat_addr, dat_wdata} = {a, d};
    step;
  endtask
  task automatic t_data;
    dacc(1, 1, 8'h90, 8'hA5);
    rest;
    dacc(1, 0, 8'h90, 8'h3C);
    rest;
    dacc(0, 1, 8'h90, 8'h00);
    chk(dat_rdata, 8'hA5);
    rest;
    dacc(0, 0, 8'h90, 8'h00);
    chk(dat_rdata, 8'h3C);
    rest;
    dacc(1, 0, 8'h7F, 8'h11);
    rest;
    dacc(0, 1, 8'h7F, 8'h00);
    chk(dat_rdata, 8'h11);
    rest;
    $display("data done");
  endtask
  task automatic t_bank;
    for (int k = 0; k < 4; k++) begin
      {reg_req, reg_we, reg_bank, reg_idx} = {2'b11, k[1:0], 3'h7};
      reg_wdata = 8'(8'h40 + k);
      step;
      rest;
      dacc(0, 1, 8'(8 * k + 7), 8'h00);
      chk(dat_rdata, 8'(8'h40 + k));
      rest;
    end
    dacc(1, 1, 8'h0A, 8'h77);
    rest;
    {reg_req, reg_we, reg_bank, reg_idx} = {2'b10, 2'h1, 3'h2};
    step;
    chk(reg_rdata, 8'h77);
    rest;
    $display("bank done");
  endtask
  task automatic t_bit;
    dacc(1, 0, 8'h2F, 8'hFF);
    rest;
    {bit_req, bit_we, bit_addr, bit_wdata} = {2'b11, 7'h7F, 1'b0};
    step;
    rest;
    dacc(0, 0, 8'h2F, 8'h00);
    chk(dat_rdata, 8'h7F);
    rest;
    {bit_req, bit_we, bit_addr} = {2'b10, 7'h7E};
    step;
    chk({7'h00, bit_rdata}, 8'h01);
    rest;
    $display("bit done");
  endtask
  task automatic t_flash;
    {fl_erase, fl_addr} = {1'b1, 13'h0800};
    step;
    chk({7'h00, fl_busy}, 8'h00);
    rest;
    {fl_erase, fl_addr} = {1'b1, FLASH_START};
    step;
    chk({7'h00, fl_busy}, 8'h01);
    rest;
    for (int i = 0; i < 600 && fl_busy === 1'b1; i++) @(negedge clk);
    code_addr = 13'h01FF;
    step;
    chk(code_data, ERASED_BYTE);
    {fl_write, fl_wdata} = {1'b1, 8'h5A};
    code_addr = FLASH_START;
    step;
    rest;
    chk(code_data, 8'h5A);
    $display("flash done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1;
    t_data;
    t_bank;
    t_bit;
    t_flash;
    final_report;
  end
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
endmodule // mem_decode_test
